// file: logic/cci_pkg.sv
package cci_pkg;
    // Register byte offsets
    localparam logic [3:0] CTRL_OFF = 4'h0;
    localparam logic [3:0] STATUS_OFF = 4'h4;
    localparam logic [3:0] CLKSEL_OFF = 4'h8;
    localparam logic [3:0] CRCREF_OFF = 4'hC;
    // CTRL fields
    localparam int CTRL_CHK_EN = 0;
    localparam int CTRL_ERR_OUT_EN = 1;
    localparam int CTRL_FREEZE = 2;
    localparam int CTRL_BOOT = 3;
    localparam int CTRL_ERR_CLR = 4;
    // STATUS fields
    localparam int ST_ERR = 0;
    localparam int ST_CONFIGURED = 1;
    localparam int ST_GOLDEN = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_FALLBACK = 4;
    localparam int ST_CRC_OK = 5;
    // Clock rates in kHz
    localparam int CLK_KHZ = 100000;
    localparam int POWERUP_KHZ = 3100;
    localparam int DEFAULT_KHZ = 2500;
    localparam int OSC_KHZ = 130000;
    // Half-period divide counts from the 100 MHz system clock
    localparam logic [15:0] POWERUP_DIV = 16'(CLK_KHZ / (2 * POWERUP_KHZ));
    localparam logic [15:0] DEFAULT_DIV = 16'(CLK_KHZ / (2 * DEFAULT_KHZ));
    // Configuration memory model size
    localparam int MEM_WORDS = 16;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
    typedef enum {CCI_IDLE, CCI_LOAD, CCI_CHECK, CCI_USER, CCI_FAIL} cci_state_t;
endpackage

// file: logic/config_clock_and_integrity.sv
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module config_clock_and_integrity
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic oscClk,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cfgValid,
    input wire logic [31:0] cfgData,
    input wire logic cfgLast,
    input wire logic [31:0] cfgCrc,
    input wire logic cfgVersionOk,
    output logic bootGolden,
    output logic bootStart,
    output logic masterConfigClock,
    output logic userOscClock,
    output logic ioFreeze,
    output logic softError
);
    logic [31:0] cfgMem [cci_pkg::MEM_WORDS];
    cci_pkg::cci_state_t state_ff;
    logic [31:0] ctrl_ff;
    logic [15:0] clkSel_ff;
    logic clkSelSeen_ff;
    logic [31:0] crcRef_ff;
    logic [31:0] loadCrc_ff;
    logic [3:0] loadIdx_ff;
    logic [3:0] sweepIdx_ff;
    logic [31:0] sweepCrc_ff;
    logic [15:0] divCnt_ff;
    logic [15:0] divLimit_ff;
    logic master_config_clock_ff;
    logic err_ff;
    logic configured_ff;
    logic golden_ff;
    logic fallback_ff;
    logic crcOk_ff;
    logic ackPending_ff;
    logic [31:0] rdata_ff;
    logic bootStart_ff;
    logic oscSel_ff;
    logic [31:0] nxt_sweepCrc;
    logic access;
    logic sweepOn;

    function automatic logic [31:0] crcStep(input logic [31:0] crc, input logic [31:0] data);
        logic [31:0] c;
        c = crc ^ data;
        for (int i = 0; i < 32; i++)
        begin
            c = c[31] ? ((c << 1) ^ cci_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    assign access = (avs_read || avs_write) && !ackPending_ff;
    assign nxt_sweepCrc = crcStep(sweepCrc_ff, cfgMem[sweepIdx_ff]);
    assign sweepOn = state_ff == cci_pkg::CCI_USER && ctrl_ff[cci_pkg::CTRL_CHK_EN];

    // One wait cycle per access, answer on second edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ackPending_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            ackPending_ff <= access;
            avs_waitrequest <= !access;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff <= cci_pkg::RESET_ZERO;
            crcRef_ff <= cci_pkg::RESET_ZERO;
        end
        else if (access && avs_write)
        begin
            if (avs_address == cci_pkg::CTRL_OFF)
            begin
                ctrl_ff <= avs_writedata;
            end
            else if (avs_address == cci_pkg::CRCREF_OFF)
            begin
                crcRef_ff <= avs_writedata;
            end
        end
        else
        begin
            // Boot request and error clear are self-clearing strobes
            ctrl_ff[cci_pkg::CTRL_BOOT] <= 1'b0;
            ctrl_ff[cci_pkg::CTRL_ERR_CLR] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_ff <= cci_pkg::RESET_ZERO;
        end
        else if (access && avs_read)
        begin
            if (avs_address == cci_pkg::CTRL_OFF)
            begin
                rdata_ff <= ctrl_ff;
            end
            else if (avs_address == cci_pkg::STATUS_OFF)
            begin
                rdata_ff <= {26'h0, crcOk_ff, fallback_ff, (state_ff == cci_pkg::CCI_LOAD),
                    golden_ff, configured_ff, err_ff};
            end
            else if (avs_address == cci_pkg::CLKSEL_OFF)
            begin
                rdata_ff <= {15'h0, clkSelSeen_ff, divLimit_ff};
            end
            else if (avs_address == cci_pkg::CRCREF_OFF)
            begin
                rdata_ff <= crcRef_ff;
            end
            else
            begin
                rdata_ff <= cci_pkg::RESET_ZERO;
            end
        end
    end
    assign avs_readdata = rdata_ff;

    // Load, check and boot sequencing
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= cci_pkg::CCI_IDLE;
            loadCrc_ff <= cci_pkg::CRC_INIT;
            loadIdx_ff <= 4'h0;
            clkSelSeen_ff <= 1'b0;
            clkSel_ff <= 16'h0;
            configured_ff <= 1'b0;
            golden_ff <= 1'b0;
            fallback_ff <= 1'b0;
            crcOk_ff <= 1'b0;
            bootStart_ff <= 1'b0;
        end
        else
        begin
            bootStart_ff <= 1'b0;
            case (state_ff)
                cci_pkg::CCI_IDLE, cci_pkg::CCI_USER:
                begin
                    if (ctrl_ff[cci_pkg::CTRL_BOOT])
                    begin
                        state_ff <= cci_pkg::CCI_LOAD;
                        loadCrc_ff <= cci_pkg::CRC_INIT;
                        loadIdx_ff <= 4'h0;
                        clkSelSeen_ff <= 1'b0;
                        configured_ff <= 1'b0;
                        golden_ff <= 1'b0;
                        fallback_ff <= 1'b0;
                        bootStart_ff <= 1'b1;
                    end
                end
                cci_pkg::CCI_LOAD:
                begin
                    if (cfgValid)
                    begin
                        loadCrc_ff <= crcStep(loadCrc_ff, cfgData);
                        if (loadIdx_ff == 4'h0 && cfgData[31])
                        begin
                            clkSel_ff <= cfgData[15:0];
                            clkSelSeen_ff <= 1'b1;
                        end
                        loadIdx_ff <= loadIdx_ff + 4'h1;
                        if (cfgLast)
                        begin
                            state_ff <= cci_pkg::CCI_CHECK;
                        end
                    end
                end
                cci_pkg::CCI_CHECK:
                begin
                    crcOk_ff <= (loadCrc_ff == cfgCrc) && cfgVersionOk;
                    if ((loadCrc_ff == cfgCrc) && cfgVersionOk)
                    begin
                        state_ff <= cci_pkg::CCI_USER;
                        configured_ff <= 1'b1;
                    end
                    else if (!golden_ff)
                    begin
                        // Retry from golden image, no power cycle needed
                        golden_ff <= 1'b1;
                        fallback_ff <= 1'b1;
                        bootStart_ff <= 1'b1;
                        loadCrc_ff <= cci_pkg::CRC_INIT;
                        loadIdx_ff <= 4'h0;
                        clkSelSeen_ff <= 1'b0;
                        state_ff <= cci_pkg::CCI_LOAD;
                    end
                    else
                    begin
                        state_ff <= cci_pkg::CCI_FAIL;
                    end
                end
                default:
                begin
                    if (ctrl_ff[cci_pkg::CTRL_BOOT])
                    begin
                        state_ff <= cci_pkg::CCI_IDLE;
                    end
                end
            endcase
        end
    end
    assign bootGolden = golden_ff;
    assign bootStart = bootStart_ff;

    // Clock divider: 3.1 MHz from power-up until bitstream decides
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divLimit_ff <= cci_pkg::POWERUP_DIV;
        end
        else if (clkSelSeen_ff && clkSel_ff != 16'h0)
        begin
            divLimit_ff <= clkSel_ff;
        end
        else if (configured_ff && !clkSelSeen_ff)
        begin
            divLimit_ff <= cci_pkg::DEFAULT_DIV;
        end
    end

    // Never gated by state, so it keeps toggling in user mode
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divCnt_ff <= 16'h0;
            master_config_clock_ff <= 1'b0;
        end
        else if (divCnt_ff + 16'h1 >= divLimit_ff)
        begin
            divCnt_ff <= 16'h0;
            master_config_clock_ff <= !master_config_clock_ff;
        end
        else
        begin
            divCnt_ff <= divCnt_ff + 16'h1;
        end
    end
    assign masterConfigClock = master_config_clock_ff;

    // Every word is kept, clock selection included, so the sweep CRC equals the load CRC
    always_ff @(posedge clk)
    begin
        if (state_ff == cci_pkg::CCI_LOAD && cfgValid)
        begin
            cfgMem[loadIdx_ff] <= cfgData;
        end
    end
    // Select is registered but the gate is combinational, so a select change may glitch
    assign userOscClock = oscClk & oscSel_ff;

    // Background sweep over whole memory, compare per pass
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sweepIdx_ff <= 4'h0;
            sweepCrc_ff <= cci_pkg::CRC_INIT;
            err_ff <= 1'b0;
        end
        else
        begin
            if (sweepOn && sweepIdx_ff != 4'(cci_pkg::MEM_WORDS - 1))
            begin
                sweepIdx_ff <= sweepIdx_ff + 4'h1;
                sweepCrc_ff <= nxt_sweepCrc;
            end
            else
            begin
                sweepIdx_ff <= 4'h0;
                sweepCrc_ff <= cci_pkg::CRC_INIT;
            end
            // Set wins over clear
            if (sweepOn && sweepIdx_ff == 4'(cci_pkg::MEM_WORDS - 1) && nxt_sweepCrc != crcRef_ff)
            begin
                err_ff <= 1'b1;
            end
            else if (ctrl_ff[cci_pkg::CTRL_ERR_CLR])
            begin
                err_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            softError <= 1'b0;
            ioFreeze <= 1'b0;
            oscSel_ff <= 1'b0;
        end
        else
        begin
            oscSel_ff <= configured_ff;
            softError <= err_ff && ctrl_ff[cci_pkg::CTRL_ERR_OUT_EN];
            ioFreeze <= ctrl_ff[cci_pkg::CTRL_FREEZE] && state_ff != cci_pkg::CCI_USER;
        end
    end
endmodule // config_clock_and_integrity

// file: tb/cci_assertions.sv
`timescale 1ns/10ps
module cci_assertions
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic oscClk,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic bootStart,
    input wire logic bootGolden,
    input wire logic masterConfigClock,
    input wire logic userOscClock,
    input wire logic softError
);
    logic lastMcc_ff;
    logic [5:0] stillCnt_ff;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Cycles since the divided clock last moved; a stall shows as a large count
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lastMcc_ff <= 1'b0;
            stillCnt_ff <= 6'h00;
        end
        else
        begin
            lastMcc_ff <= masterConfigClock;
            stillCnt_ff <= (masterConfigClock != lastMcc_ff) ? 6'h00 : stillCnt_ff + 6'h01;
        end
    end
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_taken |=> s_answer) else $error("bus answer late or long");
    a_bus_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("answer without request");
    a_boot_pulse: assert property (bootStart |=> !bootStart) else $error("boot start too long");
    a_golden_retry: assert property ($rose(bootGolden) |-> ##[0:2] bootStart) else $error("no retry");
    a_osc_gate: assert property (userOscClock |-> oscClk) else $error("user clock not from oscillator");
    a_mcc_hold: assert property ($changed(masterConfigClock) |=> $stable(masterConfigClock)[*4])
        else $error("config clock toggles too fast");
    a_mcc_runs: assert property (stillCnt_ff < 6'h18) else $error("config clock stopped");
    a_err_clear: assert property ($fell(softError) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("error output dropped without a write");
endmodule // cci_assertions
bind config_clock_and_integrity cci_assertions chk (.clk(clk), .reset_n(reset_n), .oscClk(oscClk),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .bootStart(bootStart),
    .bootGolden(bootGolden), .masterConfigClock(masterConfigClock), .userOscClock(userOscClock),
    .softError(softError));

// file: tb/cci_storage_model.sv
`timescale 1ns/10ps
module cci_storage_model
(
    input wire logic clk,
    input wire logic bootStart,
    input wire logic bootGolden,
    input wire logic [1:0] fault,
    input wire logic slow,
    output logic cfgValid,
    output logic [31:0] cfgData,
    output logic cfgLast,
    output logic [31:0] cfgCrc,
    output logic cfgVersionOk
);
    logic [31:0] img [16];
    logic [31:0] crc;
    logic gap;
    int idx;
    // Golden and new image kept apart; only the new one can be damaged
    always_comb
    begin
        crc = 32'hFFFFFFFF;
        for (int w = 0; w < 16; w++)
        begin
            img[w] = bootGolden ? 32'h00001000 + w : (w == 0 ? 32'h8000000A : 32'h5A000000 + w);
            for (int b = 31; b >= 0; b--)
                crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ img[w][b]) ? 32'h04C11DB7 : 32'h00000000);
        end
    end
    assign cfgCrc = crc ^ {31'h0, fault == 2'h1 && !bootGolden};
    assign cfgVersionOk = !(fault == 2'h2 && !bootGolden);
    initial
    begin
        idx = 16;
        gap = 1'b0;
        cfgValid = 1'b0;
        cfgLast = 1'b0;
        cfgData = 32'h00000000;
    end
    // Slow mode inserts an idle cycle between words; idle data toggles so nothing stale looks valid
    always @(posedge clk)
    begin
        gap <= !gap;
        if (!bootStart && idx < 16 && (!slow || gap))
        begin
            cfgValid <= 1'b1;
            cfgData <= img[idx];
            cfgLast <= idx == 15;
            idx <= idx + 1;
        end
        else
        begin
            cfgValid <= 1'b0;
            cfgLast <= 1'b0;
            cfgData <= ~cfgData;
            idx <= bootStart ? 0 : idx;
        end
    end
endmodule // cci_storage_model

// file: tb/tb_config_clock_and_integrity.sv
`timescale 1ns/10ps
module tb_config_clock_and_integrity;
    logic clk, reset_n, oscClk, avs_read, avs_write, avs_waitrequest, cfgValid, cfgLast, cfgVersionOk;
    logic bootGolden, bootStart, masterConfigClock, userOscClock, ioFreeze, softError, slow;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, cfgData, cfgCrc, rd;
    logic [1:0] fault;
    int numErrors, testsRun;
    config_clock_and_integrity uut (.*);
    cci_storage_model store (.*);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        oscClk = 1'b0;
        forever #3.85 oscClk = ~oscClk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            numErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Idle edge so a following call never re-raises a strobe in the same time step
        @(posedge clk);
    endtask
    task automatic rst;
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask
    // Counts clk edges between two toggles of the divided clock
    task automatic halfPeriod(output logic [31:0] n);
        logic v;
        for (int k = 0; k < 2; k++)
        begin
            v = masterConfigClock;
            n = 0;
            while (masterConfigClock === v && n < 99)
            begin
                @(posedge clk);
                n++;
            end
        end
    endtask
    task automatic tReset;
        rst();
        bus(1'b0, cci_pkg::STATUS_OFF, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, cci_pkg::CLKSEL_OFF, 32'h0, rd);
        check(rd, 32'h10);
        halfPeriod(rd);
        check(rd, 32'h10);
        bus(1'b1, 4'h6, 32'h1F, rd);
        bus(1'b0, 4'h2, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, cci_pkg::CTRL_OFF, 32'h0, rd);
        check(rd, 32'h0);
    endtask
    task automatic tBoot(input logic [1:0] f);
        logic [31:0] st;
        int n;
        fault <= f;
        slow <= f[1];
        rst();
        bus(1'b1, cci_pkg::CTRL_OFF, 32'h0C, rd);
        repeat (2) @(posedge clk);
        check(32'(ioFreeze), 32'h1);
        n = 0;
        st = 32'h0;
        while (st[1] !== 1'b1 && n < 80)
        begin
            bus(1'b0, cci_pkg::STATUS_OFF, 32'h0, st);
            n++;
        end
        check(st, f == 2'h0 ? 32'h22 : 32'h36);
        bus(1'b0, cci_pkg::CLKSEL_OFF, 32'h0, rd);
        check(rd, f == 2'h0 ? 32'h0001000A : 32'h14);
        halfPeriod(rd);
        check(rd, f == 2'h0 ? 32'hA : 32'h14);
        check(32'(ioFreeze), 32'h0);
        @(posedge oscClk);
        #1;
        check(32'(userOscClock), 32'h1);
        @(posedge clk);
    endtask
    task automatic tSed;
        logic [31:0] goodRef;
        goodRef = store.crc;
        bus(1'b1, cci_pkg::CRCREF_OFF, goodRef, rd);
        bus(1'b1, cci_pkg::CTRL_OFF, 32'h3, rd);
        repeat (40) @(posedge clk);
        check(32'(softError), 32'h0);
        bus(1'b1, cci_pkg::CRCREF_OFF, ~goodRef, rd);
        repeat (40) @(posedge clk);
        check(32'(softError), 32'h1);
        bus(1'b1, cci_pkg::CTRL_OFF, 32'h1, rd);
        repeat (3) @(posedge clk);
        check(32'(softError), 32'h0);
        bus(1'b0, cci_pkg::STATUS_OFF, 32'h0, rd);
        check(32'(rd[0]), 32'h1);
        bus(1'b1, cci_pkg::CRCREF_OFF, goodRef, rd);
        bus(1'b1, cci_pkg::CTRL_OFF, 32'h13, rd);
        repeat (40) @(posedge clk);
        check(32'(softError), 32'h0);
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #300000;
        numErrors++;
        conclude();
    end
    initial
    begin
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        fault = 2'h0;
        slow = 1'b0;
        tReset();
        // Faulty images first, the good image last so the sweep runs on it
        for (int f = 2; f >= 0; f--)
            tBoot(2'(f));
        tSed();
        conclude();
    end
endmodule // tb_config_clock_and_integrity
